// *** src/intc_prio_pick.sv ***
// shared constants and the fixed-order priority picker of the vectoring logic
// ==========================================================================
// constants
package intc_pkg;
    localparam int NSRC = 13;
    localparam int SRC_W = 4;
    localparam int CLK_NS = 20;
    localparam int MC_CLKS = 4;
    localparam int MC_NS = MC_CLKS * CLK_NS;
    localparam int CALL_MCS = 4;
    localparam int MIN_RESP_MCS = 5;
    localparam int MAX_RESP_MCS = 12;
    localparam int MAX_RESP_CLKS = MAX_RESP_MCS * MC_CLKS;
    localparam logic [2:0] CALL_CNT_INIT = 3'h4;
    localparam logic [5:0] PIN_IDLE = 6'h3F;
    localparam logic [5:0] EXT_RST = 6'h00;
    localparam logic [1:0] TMR_RST = 2'h0;
    localparam logic [1:0] INSV_RST = 2'h0;
    localparam logic [15:0] VEC_RST = 16'h0000;
    localparam logic [12:0] POLL_RST = 13'h0000;
    localparam logic [3:0] SRC_EXT0 = 4'h0;
    localparam logic [3:0] SRC_TMR0 = 4'h1;
    localparam logic [3:0] SRC_EXT1 = 4'h2;
    localparam logic [3:0] SRC_TMR1 = 4'h3;
    localparam logic [3:0] SRC_SER0 = 4'h4;
    localparam logic [3:0] SRC_TMR2 = 4'h5;
    localparam logic [3:0] SRC_SER1 = 4'h6;
    localparam logic [3:0] SRC_EXT2 = 4'h7;
    localparam logic [3:0] SRC_EXT3 = 4'h8;
    localparam logic [3:0] SRC_EXT4 = 4'h9;
    localparam logic [3:0] SRC_EXT5 = 4'hA;
    localparam logic [3:0] SRC_WDOG = 4'hB;
    localparam logic [3:0] SRC_PFAIL = 4'hC;

    typedef enum logic [1:0] {
        PH_C1 = 2'b00,
        PH_C2 = 2'b01,
        PH_C3 = 2'b11,
        PH_C4 = 2'b10
    } phase_t;

    function automatic logic [15:0] vector_of(input logic [3:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        case (idx)
            SRC_EXT0: v = 16'h0003;
            SRC_TMR0: v = 16'h000B;
            SRC_EXT1: v = 16'h0013;
            SRC_TMR1: v = 16'h001B;
            SRC_SER0: v = 16'h0023;
            SRC_TMR2: v = 16'h002B;
            SRC_SER1: v = 16'h003B;
            SRC_EXT2: v = 16'h0043;
            SRC_EXT3: v = 16'h004B;
            SRC_EXT4: v = 16'h0053;
            SRC_EXT5: v = 16'h005B;
            SRC_WDOG: v = 16'h0063;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction : vector_of
endpackage : intc_pkg

// ==========================================================================
// lowest index wins
module intc_prio_pick (
    input wire logic [12:0] req,
    output logic valid,
    output logic [3:0] idx
);
    always_comb begin
        valid = 1'b0;
        idx = 4'h0;
        for (int i = intc_pkg::NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                valid = 1'b1;
                idx = 4'(i);
            end
        end
    end
endmodule : intc_prio_pick

// *** src/intc_vectoring.sv ***
// two-level interrupt vectoring controller
// Functional notes
// - each source individually high or low, power-fail fixed high; low never preempts high
// - same level: fixed order ext0 first down to power-fail last
// - flags sampled and priority resolved within each machine cycle
// - no call while equal or higher level is in service
// - call only on final machine cycle of current instruction
// - no call during return-from-isr or priority/enable register write
// - no pending memory; each poll stands alone
// - vectoring clears timer 0 / timer 1 overflow flag
// - ext0/ext1 flag cleared on vectoring only in edge mode
// - serial and timer 2 flags untouched by vectoring
// - call pushes pc like long call, no status save, loads vector
// - fixed vector address per source
// - return-from-isr ends current routine, releases its level
// - plain return leaves in-service state unchanged
// - external pins sampled at phase C3, flags updated from sample
// - timer flags set in any phase on the overflow event, polled from next machine cycle
// - call lasts four machine cycles, five minimum to first isr op
// - response at most 12 machine cycles, four clocks per cycle
// - per-source enable and priority, power-fail always enabled and high; global enable spares power-fail
module intc_vectoring #(
    parameter logic [15:0] PFAIL_VECTOR = 16'h0100
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ext_pin_zero_n,
    input wire logic ext_pin_one_n,
    input wire logic [3:0] ext_pin_hi_n,
    input wire logic [1:0] ext_edge_mode,
    input wire logic timer0_ovf_evt,
    input wire logic timer1_ovf_evt,
    input wire logic timer2_overflow_flag,
    input wire logic timer2_external_flag,
    input wire logic serial0_rx_flag,
    input wire logic serial0_tx_flag,
    input wire logic serial1_rx_flag,
    input wire logic serial1_tx_flag,
    input wire logic watchdog_flag,
    input wire logic power_fail_flag,
    input wire logic [5:0] sw_clr_ext,
    input wire logic [1:0] sw_clr_tmr,
    input wire logic [11:0] src_enable,
    input wire logic global_enable_bit,
    input wire logic [11:0] src_prio_high,
    input wire logic core_last_cycle,
    input wire logic core_blocking_instr,
    input wire logic core_return_from_isr,
    output logic [1:0] mc_phase,
    output logic ext0_request_flag,
    output logic ext1_request_flag,
    output logic ext2_request_flag,
    output logic ext3_request_flag,
    output logic ext4_request_flag,
    output logic ext5_request_flag,
    output logic timer0_overflow_flag,
    output logic timer1_overflow_flag,
    output logic call_req,
    output logic [15:0] call_vector,
    output logic call_busy,
    output logic [1:0] in_service
);
    // ======================================================================
    // machine cycle phases
    intc_pkg::phase_t phase_r;
    intc_pkg::phase_t phase_nxt;
    logic at_c1;
    logic at_c3;
    logic at_c4;

    always_comb begin
        case (phase_r)
            intc_pkg::PH_C1: phase_nxt = intc_pkg::PH_C2;
            intc_pkg::PH_C2: phase_nxt = intc_pkg::PH_C3;
            intc_pkg::PH_C3: phase_nxt = intc_pkg::PH_C4;
            default: phase_nxt = intc_pkg::PH_C1;
        endcase
    end

    assign at_c1 = (phase_r == intc_pkg::PH_C1);
    assign at_c3 = (phase_r == intc_pkg::PH_C3);
    assign at_c4 = (phase_r == intc_pkg::PH_C4);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            phase_r <= intc_pkg::PH_C1;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    assign mc_phase = phase_r;

    // ======================================================================
    // external pin synchronisers
    logic [5:0] pin_raw;
    logic [5:0] pin_s1_r;
    logic [5:0] pin_s2_r;
    logic [5:0] pin_s3_r;
    logic [5:0] pin_val_r;
    logic [5:0] pin_val_nxt;
    logic [5:0] pin_agree;

    assign pin_raw = {ext_pin_hi_n, ext_pin_one_n, ext_pin_zero_n};
    assign pin_agree = pin_s2_r ~^ pin_s3_r;
    assign pin_val_nxt = (pin_agree & pin_s3_r) | (~pin_agree & pin_val_r);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_s1_r <= intc_pkg::PIN_IDLE;
            pin_s2_r <= intc_pkg::PIN_IDLE;
            pin_s3_r <= intc_pkg::PIN_IDLE;
            pin_val_r <= intc_pkg::PIN_IDLE;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_val_r <= pin_val_nxt;
        end
    end

    // ======================================================================
    // polling and resolution
    logic [12:0] raw_req;
    logic [12:0] poll_r;
    logic [12:0] enabled;
    logic [12:0] prio_hi_v;
    logic hi_valid;
    logic lo_valid;
    logic [3:0] hi_idx;
    logic [3:0] lo_idx;
    logic win_valid;
    logic [3:0] win_idx;
    logic [12:0] win_oh;
    logic level_ok;
    logic take;
    logic [15:0] win_vector;
    logic [2:0] busy_cnt_r;
    logic [2:0] busy_cnt_nxt;
    logic [5:0] ext_flag_r;
    logic [1:0] tmr_flag_r;

    assign raw_req = {power_fail_flag, watchdog_flag, ext_flag_r[5:2],
                      serial1_rx_flag | serial1_tx_flag,
                      timer2_overflow_flag | timer2_external_flag,
                      serial0_rx_flag | serial0_tx_flag,
                      tmr_flag_r[1], ext_flag_r[1], tmr_flag_r[0],
                      ext_flag_r[0]};

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            poll_r <= intc_pkg::POLL_RST;
        end else if (at_c1) begin
            poll_r <= raw_req;
        end
    end

    assign enabled = poll_r &
        {1'b1, src_enable & {12{global_enable_bit}}};
    assign prio_hi_v = {1'b1, src_prio_high};

    intc_prio_pick u_pick_hi (
        .req(enabled & prio_hi_v),
        .valid(hi_valid),
        .idx(hi_idx)
    );

    intc_prio_pick u_pick_lo (
        .req(enabled & ~prio_hi_v),
        .valid(lo_valid),
        .idx(lo_idx)
    );

    assign win_valid = hi_valid | lo_valid;
    assign win_idx = hi_valid ? hi_idx : lo_idx;
    assign win_oh = 13'(13'h0001 << win_idx);
    assign level_ok = hi_valid ? ~in_service[1] : ~(|in_service);
    assign take = at_c4 & win_valid & level_ok & core_last_cycle
        & ~core_blocking_instr & (busy_cnt_r == 3'h0);
    assign win_vector = (win_idx == intc_pkg::SRC_PFAIL) ? PFAIL_VECTOR
        : intc_pkg::vector_of(win_idx);

    // ======================================================================
    // call sequencing and in-service levels
    logic [1:0] insv_set;
    logic [1:0] insv_clr;

    assign busy_cnt_nxt = take ? intc_pkg::CALL_CNT_INIT
        : ((at_c4 && busy_cnt_r != 3'h0) ? busy_cnt_r - 3'h1 : busy_cnt_r);
    assign insv_set = take ? (hi_valid ? 2'h2 : 2'h1) : 2'h0;
    assign insv_clr = core_return_from_isr
        ? (in_service[1] ? 2'h2 : 2'h1) : 2'h0;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            busy_cnt_r <= 3'h0;
            call_busy <= 1'b0;
            call_req <= 1'b0;
            call_vector <= intc_pkg::VEC_RST;
            in_service <= intc_pkg::INSV_RST;
        end else begin
            busy_cnt_r <= busy_cnt_nxt;
            call_busy <= (busy_cnt_nxt != 3'h0);
            call_req <= take;
            if (take) begin
                call_vector <= win_vector;
            end
            in_service <= (in_service & ~insv_clr) | insv_set;
        end
    end

    // ======================================================================
    // request flags
    logic [5:0] ext_smp_r;
    logic [5:0] ext_edge_v;
    logic [5:0] ext_set;
    logic [5:0] ext_clr;
    logic [5:0] call_clr_ext;
    logic [5:0] ext_flag_nxt;
    logic [1:0] tmr_clr;
    logic [1:0] tmr_flag_nxt;

    assign ext_edge_v = {4'hF, ext_edge_mode};
    assign ext_set = {6{at_c3}} & ext_edge_v & ext_smp_r & ~pin_val_r;
    assign call_clr_ext = {4'h0, win_oh[intc_pkg::SRC_EXT1],
        win_oh[intc_pkg::SRC_EXT0]} & ext_edge_v & {6{take}};
    assign ext_clr = sw_clr_ext | call_clr_ext;
    assign ext_flag_nxt = (ext_edge_v & ((ext_flag_r & ~ext_clr) | ext_set))
        | (~ext_edge_v & (at_c3 ? ~pin_val_r : ext_flag_r & ~sw_clr_ext));
    assign tmr_clr = sw_clr_tmr | ({win_oh[intc_pkg::SRC_TMR1],
        win_oh[intc_pkg::SRC_TMR0]} & {2{take}});
    assign tmr_flag_nxt = (tmr_flag_r & ~tmr_clr)
        | {timer1_ovf_evt, timer0_ovf_evt};

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ext_smp_r <= intc_pkg::PIN_IDLE;
            ext_flag_r <= intc_pkg::EXT_RST;
            tmr_flag_r <= intc_pkg::TMR_RST;
        end else begin
            if (at_c3) begin
                ext_smp_r <= pin_val_r;
            end
            ext_flag_r <= ext_flag_nxt;
            tmr_flag_r <= tmr_flag_nxt;
        end
    end

    assign ext0_request_flag = ext_flag_r[0];
    assign ext1_request_flag = ext_flag_r[1];
    assign ext2_request_flag = ext_flag_r[2];
    assign ext3_request_flag = ext_flag_r[3];
    assign ext4_request_flag = ext_flag_r[4];
    assign ext5_request_flag = ext_flag_r[5];
    assign timer0_overflow_flag = tmr_flag_r[0];
    assign timer1_overflow_flag = tmr_flag_r[1];

    // ======================================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    call_on_last_a: assert property (call_req |->
        $past(phase_r) == intc_pkg::PH_C4 && $past(core_last_cycle))
        else $error("call outside final machine cycle");
    call_not_blocked_a: assert property (call_req |->
        !$past(core_blocking_instr))
        else $error("call during blocking instruction");
    call_four_cycles_a: assert property (call_req |->
        ##15 call_busy ##1 !call_busy)
        else $error("call length is not four machine cycles");
    no_preempt_high_a: assert property (call_req |->
        !$past(in_service[1]))
        else $error("call while high level in service");
    ext0_first_a: assert property (call_req &&
        $past(enabled[0] && (prio_hi_v[0] || !hi_valid)) |->
        call_vector == intc_pkg::vector_of(intc_pkg::SRC_EXT0))
        else $error("ext0 did not win");
    timer0_cleared_a: assert property (call_req &&
        call_vector == intc_pkg::vector_of(intc_pkg::SRC_TMR0) |->
        !timer0_overflow_flag || $past(timer0_ovf_evt))
        else $error("timer0 flag not cleared on vectoring");
    level_ext_kept_a: assert property (call_req &&
        call_vector == intc_pkg::vector_of(intc_pkg::SRC_EXT1) &&
        !$past(ext_edge_mode[1]) && !$past(sw_clr_ext[1]) |->
        ext1_request_flag == $past(ext1_request_flag))
        else $error("level ext1 flag changed on vectoring");
    return_from_isr_release_a: assert property (core_return_from_isr && in_service[1] &&
        !take |=> !in_service[1])
        else $error("return did not release high level");
    timer1_cleared_a: assert property (call_req &&
        call_vector == intc_pkg::vector_of(intc_pkg::SRC_TMR1) |->
        !timer1_overflow_flag || $past(timer1_ovf_evt))
        else $error("timer1 flag not cleared on vectoring");
    edge_ext_cleared_a: assert property (call_req &&
        call_vector == intc_pkg::vector_of(intc_pkg::SRC_EXT0) &&
        $past(ext_edge_mode[0]) |-> !ext0_request_flag)
        else $error("edge ext0 flag not cleared on vectoring");
    level_set_a: assert property (call_req |->
        ($past(hi_valid) ? in_service[1] : in_service[0]))
        else $error("in-service bit not set by call");
endmodule : intc_vectoring

// *** testbench/cpu_model.sv ***
// cpu sequencer model: instruction boundaries, blocking flag, stack depth
// ==========================================================================
// model
module cpu_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [1:0] mc_phase,
    input wire logic call_req,
    input wire logic return_from_isr_cmd,
    input wire logic block,
    output logic core_last_cycle,
    output logic core_blocking_instr,
    output logic core_return_from_isr,
    output logic [3:0] stack_depth
);
    timeunit 1ns;
    timeprecision 1ns;
    logic odd_r;
    logic [3:0] depth_r;
    // two machine cycles per instruction, last one flagged
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            odd_r <= 1'b0;
            core_return_from_isr <= 1'b0;
            depth_r <= 4'h0;
        end else begin
            if (mc_phase == intc_pkg::PH_C4) odd_r <= ~odd_r;
            core_return_from_isr <= return_from_isr_cmd;
            if (call_req) depth_r <= depth_r + 4'h1;
            else if (core_return_from_isr) depth_r <= depth_r - 4'h1;
        end
    end
    assign core_last_cycle = odd_r;
    assign core_blocking_instr = block | core_return_from_isr;
    assign stack_depth = depth_r;
endmodule : cpu_model

// *** testbench/two_level_interrupt_vectoring_tb_top.sv ***
// self-checking bench for the interrupt vectoring controller
// ==========================================================================
// bench
module two_level_interrupt_vectoring_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, sys_rst, ext_pin_zero_n, ext_pin_one_n, call_req, call_busy;
    logic timer0_ovf_evt, timer1_ovf_evt, power_fail_flag, global_enable_bit;
    logic core_last_cycle, core_blocking_instr, core_return_from_isr, return_from_isr_cmd, block;
    logic ext0_request_flag, ext1_request_flag, ext2_request_flag;
    logic ext3_request_flag, ext4_request_flag, ext5_request_flag;
    logic timer0_overflow_flag, timer1_overflow_flag;
    logic [3:0] ext_pin_hi_n, held, stack_depth;
    logic [1:0] ext_edge_mode, sw_clr_tmr, mc_phase, in_service;
    logic [5:0] sw_clr_ext;
    logic [11:0] src_enable, src_prio_high;
    logic [15:0] call_vector;
    logic [15:0] exp_q[$];
    int bad_count, compares, calls, seed, i;
    intc_vectoring #(.PFAIL_VECTOR(16'h0100)) dut (.core_clk, .sys_rst,
        .ext_pin_zero_n, .ext_pin_one_n, .ext_pin_hi_n, .ext_edge_mode,
        .timer0_ovf_evt, .timer1_ovf_evt, .timer2_overflow_flag(1'b0),
        .timer2_external_flag(held[1]), .serial0_rx_flag(1'b0),
        .serial0_tx_flag(held[0]), .serial1_rx_flag(held[2]),
        .serial1_tx_flag(1'b0), .watchdog_flag(held[3]), .power_fail_flag,
        .sw_clr_ext, .sw_clr_tmr, .src_enable, .global_enable_bit,
        .src_prio_high, .core_last_cycle, .core_blocking_instr, .core_return_from_isr,
        .mc_phase, .ext0_request_flag, .ext1_request_flag, .ext2_request_flag,
        .ext3_request_flag, .ext4_request_flag, .ext5_request_flag,
        .timer0_overflow_flag, .timer1_overflow_flag, .call_req,
        .call_vector, .call_busy, .in_service);
    cpu_model cpu (.core_clk, .sys_rst, .mc_phase, .call_req, .return_from_isr_cmd,
        .block, .core_last_cycle, .core_blocking_instr, .core_return_from_isr,
        .stack_depth);
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    // monitor: each call is matched against the oldest note
    always @(negedge core_clk) begin
        if (call_req === 1'b1) begin
            calls++;
            if (exp_q.size() == 0) begin
                check("call_vector", call_vector, 16'hFFFF);
            end else begin
                check("call_vector", call_vector, exp_q.pop_front());
            end
        end
    end
    task automatic clk(int n);
        repeat (n) @(posedge core_clk);
    endtask : clk
    task automatic wait_call(logic [15:0] v);
        int n0;
        int k;
        n0 = calls;
        exp_q.push_back(v);
        for (k = 0; k < 400 && calls == n0; k++) clk(1);
        if (calls == n0) begin
            check("call_seen", 16'h0, 16'h1);
            end_of_test();
        end
        clk(2);
    endtask : wait_call
    task automatic quiet(int mcs);
        int n0;
        n0 = calls;
        clk(mcs * 4);
        check("no_call", calls[15:0], n0[15:0]);
    endtask : quiet
    task automatic return_from_isr();
        clk(1);
        return_from_isr_cmd <= 1'b1;
        clk(1);
        return_from_isr_cmd <= 1'b0;
        clk(3);
    endtask : return_from_isr
    initial begin
        seed = 32'h92d741b8;
        {sys_rst, ext_pin_zero_n, ext_pin_one_n, ext_pin_hi_n} = 7'h7F;
        {timer0_ovf_evt, timer1_ovf_evt, power_fail_flag, return_from_isr_cmd} = 4'h0;
        {held, sw_clr_ext, sw_clr_tmr, ext_edge_mode, block} = 15'h0000;
        {global_enable_bit, src_enable, src_prio_high} = {13'h1FFF, 12'h000};
        clk(6);
        sys_rst <= 1'b0;
        clk(4);
        // order among held low-level flags
        held <= 4'hF;
        for (i = 0; i < 4; i++) begin
            wait_call(i == 3 ? 16'h0063 : i == 2 ? 16'h003B
                : 16'h0023 + 16'(i) * 16'h0008);
            check("in_service", 16'(in_service), 16'h0001);
            quiet(3);
            held[i] <= 1'b0;
            return_from_isr();
        end
        $display("test order done");
        // global enable off spares power fail only
        global_enable_bit <= 1'b0;
        power_fail_flag <= 1'b1;
        held[3] <= 1'b1;
        wait_call(16'h0100);
        check("in_service", 16'(in_service), 16'h0002);
        power_fail_flag <= 1'b0;
        return_from_isr();
        quiet(4);
        held[3] <= 1'b0;
        global_enable_bit <= 1'b1;
        $display("test global done");
        // high preempts low, low waits for low level release
        src_prio_high[3] <= 1'b1;
        held[0] <= 1'b1;
        wait_call(16'h0023);
        timer1_ovf_evt <= 1'b1;
        clk(1);
        timer1_ovf_evt <= 1'b0;
        wait_call(16'h001B);
        check("in_service", 16'(in_service), 16'h0003);
        check("t1_flag", 16'(timer1_overflow_flag), 16'h0000);
        timer0_ovf_evt <= 1'b1;
        clk(1);
        timer0_ovf_evt <= 1'b0;
        quiet(3);
        check("t0_flag", 16'(timer0_overflow_flag), 16'h0001);
        held[0] <= 1'b0;
        return_from_isr();
        quiet(3);
        check("in_service", 16'(in_service), 16'h0001);
        return_from_isr();
        wait_call(16'h000B);
        check("t0_flag", 16'(timer0_overflow_flag), 16'h0000);
        return_from_isr();
        $display("test levels done");
        // external pins: edge and level modes
        ext_edge_mode <= 2'b01;
        ext_pin_zero_n <= 1'b0;
        clk(8);
        ext_pin_zero_n <= 1'b1;
        wait_call(16'h0003);
        check("ext0_flag", 16'(ext0_request_flag), 16'h0000);
        return_from_isr();
        ext_pin_one_n <= 1'b0;
        wait_call(16'h0013);
        check("ext1_flag", 16'(ext1_request_flag), 16'h0001);
        ext_pin_one_n <= 1'b1;
        clk(16);
        return_from_isr();
        for (i = 0; i < 4; i++) begin
            ext_pin_hi_n[i] <= 1'b0;
            clk(8);
            ext_pin_hi_n[i] <= 1'b1;
            wait_call(16'h0043 + 16'(i) * 16'h0008);
            sw_clr_ext[i + 2] <= 1'b1;
            clk(1);
            sw_clr_ext[i + 2] <= 1'b0;
            return_from_isr();
        end
        $display("test pins done");
        // request held only while blocked is forgotten
        block <= 1'b1;
        held[1] <= 1'b1;
        clk(4 * (2 + ($unsigned($random(seed)) % 4)));
        held[1] <= 1'b0;
        clk(8);
        block <= 1'b0;
        quiet(4);
        check("stack_depth", 16'(stack_depth), 16'h0000);
        check("notes_left", 16'(exp_q.size()), 16'h0000);
        $display("test denied done");
        end_of_test();
    end
endmodule : two_level_interrupt_vectoring_tb_top
